/* scs_map.svh */
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH
`define SCS_CODE_NONE 3'h0
`define SCS_CODE_FULL 3'h1
`define SCS_CODE_LOW 3'h2
`define SCS_CODE_TOO_LOW 3'h3
`define SCS_CODE_TOO_HIGH 3'h4
`define SCS_CODE_FLOAT_HIGH 3'h5
`define SCS_CODE_RECOVERED 3'h6
`define SCS_MEAS_IIN 2'h0
`define SCS_MEAS_VIN 2'h1
`define SCS_MEAS_IOUT 2'h2
`define SCS_MEAS_VOUT 2'h3
`define SCS_SETPT_REG 8'h03
`define SCS_SETPT_LSB 20
`define SCS_APPLY_BIT 46
`define SCS_CMD_BYTES 4'h8
`define SCS_MEAS_MAX 10'h03ff
`define SCS_DEV_ADDR 7'h01
`define SCS_WDT_NS 1000000
`define SCS_CLK_NS 100
`endif

/* scs_pkg.sv */
package scs_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_FETCH = 6'b00_0010,
        ST_EVAL = 6'b00_0100,
        ST_SEND = 6'b00_1000,
        ST_WAIT = 6'b01_0000,
        ST_DONE = 6'b10_0000
    } scs_state_t;
    typedef logic [15:0] scs_slot_t;
endpackage : scs_pkg

/* scs_link_if.sv */
`timescale 1ns/1ns
interface scs_link_if;
    logic rd_start;
    logic wr_start;
    logic [3:0] wr_count;
    logic [7:0] wr_byte;
    logic [3:0] wr_index;
    logic busy;
    logic rd_valid;
    logic [1:0] rd_slot;
    logic [9:0] rd_data;
    modport master (
        output rd_start, wr_start, wr_count, wr_byte,
        input busy, rd_valid, rd_slot, rd_data, wr_index
    );
    modport engine (
        input rd_start, wr_start, wr_count, wr_byte,
        output busy, rd_valid, rd_slot, rd_data, wr_index
    );
endinterface : scs_link_if

/* scs_i2c_engine.sv */
`timescale 1ns/1ns
`include "scs_map.svh"
// Byte-level I2C engine: sends counted bytes and reads four 10-bit values.
module scs_i2c_engine #(
    parameter int DIV = 25
) (
    input wire logic sys_clk,
    input wire logic rst,
    scs_link_if.engine lk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic scl_out
);
    // A sample lands one tick after the low half, and the two-flop delay needs four cycles of it.
    initial if (DIV < 4 || DIV > 256) $error("DIV out of range");
    logic [7:0] div_q;
    logic tick;
    logic [3:0] phase_q;
    logic [3:0] bit_q;
    logic [3:0] byte_q;
    logic [3:0] total_q;
    logic rd_mode_q;
    logic [7:0] sh_q;
    logic [15:0] acc_q;
    logic [1:0] slot_q;
    logic sda_s1_q, sda_s2_q;
    logic drive_low_q;
    logic run_q;
    assign tick = (div_q == 8'(DIV - 1));
    assign lk.busy = run_q;
    // Point at the next byte, so that the byte boundary loads it and not the one just sent.
    assign lk.wr_index = run_q ? byte_q + 4'h1 : 4'h0;
    assign sda_out = 1'b0;
    assign sda_oe_n = ~drive_low_q;
    always_ff @(posedge sys_clk)
    begin
        sda_s1_q <= sda_in;
        sda_s2_q <= sda_s1_q;
    end
    always_ff @(posedge sys_clk)
    begin
        if (rst || tick)
            div_q <= 8'h00;
        else
            div_q <= div_q + 8'h01;
    end
    // Each bit takes two ticks: low half drives data, high half samples and shifts.
    always_ff @(posedge sys_clk)
    begin
        lk.rd_valid <= 1'b0;
        if (rst)
        begin
            run_q <= 1'b0;
            scl_out <= 1'b1;
            drive_low_q <= 1'b0;
            phase_q <= 4'h0;
            bit_q <= 4'h0;
            byte_q <= 4'h0;
            total_q <= 4'h0;
            rd_mode_q <= 1'b0;
            sh_q <= 8'h00;
            acc_q <= 16'h0000;
            slot_q <= 2'h0;
            lk.rd_slot <= 2'h0;
            lk.rd_data <= 10'h000;
        end
        else if (!run_q)
        begin
            if (lk.wr_start || lk.rd_start)
            begin
                run_q <= 1'b1;
                rd_mode_q <= lk.rd_start;
                total_q <= lk.rd_start ? 4'h8 : lk.wr_count;
                byte_q <= 4'h0;
                bit_q <= 4'h0;
                slot_q <= 2'h0;
                drive_low_q <= 1'b1;
                sh_q <= lk.rd_start ? {`SCS_DEV_ADDR, 1'b1} : lk.wr_byte;
            end
        end
        else if (tick)
        begin
            phase_q <= phase_q ^ 4'h1;
            if (phase_q[0] == 1'b0)
            begin
                scl_out <= 1'b0;
                if (bit_q < 4'h8)
                    drive_low_q <= rd_mode_q ? 1'b0 : ~sh_q[7];
                else
                    drive_low_q <= rd_mode_q;
            end
            else
            begin
                scl_out <= 1'b1;
                if (bit_q < 4'h8)
                begin
                    sh_q <= {sh_q[6:0], sda_s2_q};
                    bit_q <= bit_q + 4'h1;
                end
                else
                begin
                    bit_q <= 4'h0;
                    byte_q <= byte_q + 4'h1;
                    sh_q <= lk.wr_byte;
                    if (rd_mode_q && byte_q[0])
                    begin
                        lk.rd_valid <= 1'b1;
                        lk.rd_slot <= slot_q;
                        lk.rd_data <= {acc_q[1:0], sh_q};
                        slot_q <= slot_q + 2'h1;
                    end
                    acc_q <= {acc_q[7:0], sh_q};
                    if (byte_q + 4'h1 >= total_q)
                    begin
                        run_q <= 1'b0;
                        drive_low_q <= 1'b0;
                        scl_out <= 1'b1;
                    end
                end
            end
        end
    end
endmodule : scs_i2c_engine

/* scs_watchdog.sv */
`timescale 1ns/1ns
`include "scs_map.svh"
// Watchdog: times out if the main loop stops kicking it.
module scs_watchdog #(
    parameter int LIMIT = `SCS_WDT_NS / `SCS_CLK_NS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic kick,
    output logic expired
);
    initial if (LIMIT < 2) $error("LIMIT too small");
    logic [23:0] cnt_q;
    always_ff @(posedge sys_clk)
    begin
        if (rst || kick)
            cnt_q <= 24'h00_0000;
        else if (!expired)
            cnt_q <= cnt_q + 24'h00_0001;
    end
    assign expired = (cnt_q >= 24'(LIMIT));
endmodule : scs_watchdog

/* scs_charge_sequencer.sv */
`timescale 1ns/1ns
`include "scs_map.svh"
// How it works
// - Code 1 sends the float voltage setpoint over I2C.
// - Code 2 switches to trickle charging.
// - Codes 3 or 4 set the hold bit, keeping converter in reset.
// - Code 5 holds converter in reset and sets hysteresis flag.
// - Code 6 releases reset unless the Li-ion charge is done, and clears hysteresis flag, only while that flag is set.
// - The watchdog is kicked exactly once per loop pass.
// - Each pass fetches measurements first, then evaluates the code.
// - Measurements are 10-bit unsigned, full scale 1023, low bits of slot.
// - Four 16-bit slots: input current, input voltage, output current, output voltage.
// - A transmission sends a given byte count from buffer index zero upward.
// - The target routine transmits the stored output voltage target.
// - Near-zero output current enables the start-up assist, only while the hold bit is clear.
// - Li-ion cut-off needs voltage at limit and current under threshold.
// - After Li-ion cut-off no trickle charge is applied.
// - Code 0x3FF means 5V at the output-voltage sense input.
// - Setpoint is re-sent whenever the converter leaves reset.
// - Setpoint goes to register 0x03, bits 20:29, apply bit 46.
// - Code 5 comes from float voltage above 13.6V.
// - Panel readings are invalid while the start-up assist is on.
module scs_charge_sequencer #(
    parameter int I2C_DIV = 25,
    parameter int WDT_LIMIT = `SCS_WDT_NS / `SCS_CLK_NS,
    parameter int LOW_CUR = 10'h008
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] battery_state_code,
    input wire logic state_valid,
    input wire logic liion_mode,
    input wire logic [9:0] voutmax,
    input wire logic [9:0] liion_vlimit,
    input wire logic [9:0] liion_cur_limit,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic scl_out,
    output logic converter_hold_bit,
    output logic trickle_mode,
    output logic hysteresis_flag,
    output logic startup_assist,
    output logic charge_done,
    output logic panel_valid,
    output logic wdt_expired,
    output logic loop_tick,
    output scs_pkg::scs_slot_t meas_iin,
    output scs_pkg::scs_slot_t meas_vin,
    output scs_pkg::scs_slot_t meas_iout,
    output scs_pkg::scs_slot_t meas_vout
);
    import scs_pkg::*;
    initial if (LOW_CUR > 1023) $error("LOW_CUR out of range");
    scs_link_if lk ();
    scs_state_t st_q;
    scs_slot_t outval_q [4];
    logic [7:0] buf_q [8];
    logic [2:0] code_q;
    logic hold_prev_q;
    logic resend_q;
    logic [47:0] frame;
    logic [63:0] cmd_word;
    logic cutoff_hit;
    logic done_now;
    logic wdt_kick;

    ////////////////////////////////////////////////////////////////////////
    scs_i2c_engine #(
        .DIV(I2C_DIV)
    ) u_eng (
        .sys_clk(sys_clk),
        .rst(rst),
        .lk(lk.engine),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .scl_out(scl_out)
    );
    scs_watchdog #(
        .LIMIT(WDT_LIMIT)
    ) u_wdt (
        .sys_clk(sys_clk),
        .rst(rst),
        .kick(wdt_kick),
        .expired(wdt_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // The full-scale code maps to 5V at the sense input, so voutmax is sent raw.
    always_comb
    begin
        frame = 48'h0000_0000_0000;
        frame[`SCS_SETPT_LSB +: 10] = voutmax;
        frame[`SCS_APPLY_BIT] = 1'b1;
    end
    // Address byte first, then the register, then the setpoint word from its low byte up.
    assign cmd_word = {frame, `SCS_SETPT_REG, `SCS_DEV_ADDR, 1'b0};
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_buf
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    buf_q[gi] <= 8'h00;
                else if (st_q == ST_EVAL)
                    buf_q[gi] <= cmd_word[gi * 8 +: 8];
            end
        end
    endgenerate
    assign lk.wr_byte = buf_q[lk.wr_index[2:0]];
    assign lk.wr_count = `SCS_CMD_BYTES;
    assign lk.rd_start = (st_q == ST_FETCH) && !lk.busy;
    assign lk.wr_start = (st_q == ST_SEND) && !lk.busy;

    ////////////////////////////////////////////////////////////////////////
    // Loop sequence: fetch, evaluate, optional send, then one watchdog kick.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            st_q <= ST_IDLE;
        else
        begin
            case (st_q)
                ST_IDLE: st_q <= ST_FETCH;
                ST_FETCH: if (!lk.busy) st_q <= ST_WAIT;
                ST_WAIT: if (!lk.busy) st_q <= state_valid ? ST_EVAL : ST_WAIT;
                ST_EVAL:
                    if (code_q == `SCS_CODE_FULL || resend_q)
                        st_q <= ST_SEND;
                    else
                        st_q <= ST_DONE;
                ST_SEND: if (!lk.busy) st_q <= ST_DONE;
                ST_DONE: if (!lk.busy) st_q <= ST_FETCH;
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    assign wdt_kick = (st_q == ST_DONE) && !lk.busy;
    assign loop_tick = wdt_kick;
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            code_q <= `SCS_CODE_NONE;
        else if (st_q == ST_WAIT)
            code_q <= battery_state_code;
    end

    ////////////////////////////////////////////////////////////////////////
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_meas
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    outval_q[gi] <= 16'h0000;
                else if (lk.rd_valid && lk.rd_slot == 2'(gi))
                    outval_q[gi] <= {6'h00, lk.rd_data};
            end
        end
    endgenerate
    assign meas_iin = outval_q[`SCS_MEAS_IIN];
    assign meas_vin = outval_q[`SCS_MEAS_VIN];
    assign meas_iout = outval_q[`SCS_MEAS_IOUT];
    assign meas_vout = outval_q[`SCS_MEAS_VOUT];
    assign panel_valid = !startup_assist;

    ////////////////////////////////////////////////////////////////////////
    // Hold, hysteresis and trickle act on the code once per pass.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            converter_hold_bit <= 1'b1;
            hysteresis_flag <= 1'b0;
            trickle_mode <= 1'b0;
        end
        else if (st_q == ST_EVAL)
        begin
            case (code_q)
                `SCS_CODE_FULL: converter_hold_bit <= charge_done;
                `SCS_CODE_LOW:
                begin
                    trickle_mode <= !(liion_mode && done_now);
                    converter_hold_bit <= liion_mode && done_now;
                end
                `SCS_CODE_TOO_LOW, `SCS_CODE_TOO_HIGH: converter_hold_bit <= 1'b1;
                `SCS_CODE_FLOAT_HIGH:
                begin
                    converter_hold_bit <= 1'b1;
                    hysteresis_flag <= 1'b1;
                end
                `SCS_CODE_RECOVERED:
                    if (hysteresis_flag)
                    begin
                        converter_hold_bit <= charge_done;
                        hysteresis_flag <= 1'b0;
                    end
                default: ;
            endcase
            // The cut-off acts in the pass that detects it, so no trickle slips through.
            if (done_now)
            begin
                converter_hold_bit <= 1'b1;
                trickle_mode <= 1'b0;
            end
        end
    end
    // A Li-ion charge ends only when voltage and current agree, since dim light also drops current.
    always_ff @(posedge sys_clk)
    begin
        if (rst || !liion_mode)
            charge_done <= 1'b0;
        else if (cutoff_hit)
            charge_done <= 1'b1;
    end
    assign cutoff_hit = (st_q == ST_EVAL) && liion_mode && meas_vout >= {6'h00, liion_vlimit}
                        && meas_iout < {6'h00, liion_cur_limit};
    assign done_now = charge_done || cutoff_hit;
    // Re-send the setpoint after each release, since the controller loses it in reset.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            hold_prev_q <= 1'b1;
            resend_q <= 1'b0;
        end
        else
        begin
            hold_prev_q <= converter_hold_bit;
            if (hold_prev_q && !converter_hold_bit)
                resend_q <= 1'b1;
            else if (st_q == ST_SEND && !lk.busy)
                resend_q <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            startup_assist <= 1'b0;
        else if (st_q == ST_EVAL)
            startup_assist <= !converter_hold_bit && meas_iout < 16'(LOW_CUR);
    end
endmodule : scs_charge_sequencer

/* scs_seq_monitor.sv */
`timescale 1ns/1ns
module scs_seq_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic converter_hold_bit,
    input wire logic hysteresis_flag,
    input wire logic trickle_mode,
    input wire logic startup_assist,
    input wire logic charge_done,
    input wire logic panel_valid,
    input wire logic wdt_expired,
    input wire logic loop_tick,
    input wire logic scl_out,
    input wire logic sda_oe_n,
    input wire scs_pkg::scs_slot_t meas_iin,
    input wire scs_pkg::scs_slot_t meas_vout
);
    import scs_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    reset_state_a: assert property (disable iff (1'b0) rst |=> converter_hold_bit
        && !hysteresis_flag && scl_out && sda_oe_n) else $error("Reset state wrong.");
    panel_flag_a: assert property (panel_valid == !startup_assist)
        else $error("Panel valid flag wrong.");
    meas_width_a: assert property (meas_iin[15:10] == 6'h0 && meas_vout[15:10] == 6'h0)
        else $error("Measurement above ten bits.");
    hyst_set_a: assert property ($rose(hysteresis_flag) |-> converter_hold_bit)
        else $error("Hysteresis set without hold.");
    hyst_clear_a: assert property ($fell(hysteresis_flag) && !charge_done |-> !converter_hold_bit)
        else $error("Hysteresis cleared without release.");
    done_holds_a: assert property (charge_done |-> converter_hold_bit && !trickle_mode)
        else $error("Charge after cut-off.");
    tick_pulse_a: assert property (loop_tick |=> !loop_tick [*8])
        else $error("Loop ticks too close.");
    wdt_kick_a: assert property (loop_tick |-> ##2 !wdt_expired)
        else $error("Watchdog expired despite kick.");
    cover property (hysteresis_flag ##1 !hysteresis_flag);
    cover property (charge_done);
    cover property (startup_assist);
endmodule : scs_seq_monitor

bind scs_charge_sequencer scs_seq_monitor u_scs_seq_monitor (.sys_clk(sys_clk), .rst(rst),
    .converter_hold_bit(converter_hold_bit), .hysteresis_flag(hysteresis_flag),
    .trickle_mode(trickle_mode), .startup_assist(startup_assist), .charge_done(charge_done),
    .panel_valid(panel_valid), .wdt_expired(wdt_expired), .loop_tick(loop_tick),
    .scl_out(scl_out), .sda_oe_n(sda_oe_n), .meas_iin(meas_iin), .meas_vout(meas_vout));

/* scs_conv_model.sv */
`timescale 1ns/1ns
// Far-side converter controller answering on an open-drain data line.
module scs_conv_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl_out,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic converter_hold_bit,
    input wire logic zero_data,
    output logic sda_in,
    output int edge_cnt,
    output logic [71:0] frame_bits
);
    logic scl_q;
    logic pat_q;
    always_ff @(posedge sys_clk)
    begin
        scl_q <= scl_out;
        if (rst)
        begin
            edge_cnt <= 0;
            pat_q <= 1'b0;
            frame_bits <= 72'h0;
        end
        else
        begin
            if (scl_out && !scl_q)
            begin
                edge_cnt <= edge_cnt + 1;
                // The last nine-bit slots seen hold one whole setpoint command.
                frame_bits <= {frame_bits[70:0], sda_oe_n | sda_out};
            end
            if (!scl_out && scl_q)
            begin
                // Changes every bit so a stale value never passes for a fresh one.
                pat_q <= ~pat_q;
            end
        end
    end
    // A controller held in reset lets go of the line and the pull-up wins.
    assign sda_in = !sda_oe_n ? sda_out : (zero_data ? 1'b0 : (converter_hold_bit | pat_q));
endmodule : scs_conv_model

/* scs_charge_sequencer_tb.sv */
`timescale 1ns/1ns
`include "scs_map.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got=%h exp=%h", $time, (a), (e)); end end
module scs_charge_sequencer_tb;
    import scs_pkg::*;
    localparam int WDT = 3000;
    localparam int SEND_BITS = `SCS_CMD_BYTES * 8;
    localparam logic [9:0] VSET = 10'h02c5;
    localparam logic [47:0] SET_WORD = (48'(VSET) << `SCS_SETPT_LSB) | (48'h1 << `SCS_APPLY_BIT);
    localparam logic [71:0] EXP_FRAME = {{`SCS_DEV_ADDR, 1'b0}, 1'b1, `SCS_SETPT_REG, 1'b1,
        SET_WORD[7:0], 1'b1, SET_WORD[15:8], 1'b1, SET_WORD[23:16], 1'b1,
        SET_WORD[31:24], 1'b1, SET_WORD[39:32], 1'b1, SET_WORD[47:40], 1'b1};
    logic [71:0] frame_bits;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] code = 3'h0;
    logic valid = 1'b1;
    logic liion = 1'b0;
    logic [9:0] vlim = 10'h3ff;
    logic zero_data = 1'b0;
    logic sda_in, sda_out, sda_oe_n, scl_out, hold, trickle, hyst, assist, done, panel;
    logic wdt, tick;
    scs_slot_t m_iin, m_vin, m_iout, m_vout;
    int edge_cnt, n_fail = 0, compares = 0, cyc = 0, e0, e;
    always #50 sys_clk = ~sys_clk;
    scs_charge_sequencer #(.I2C_DIV(4), .WDT_LIMIT(WDT)) u_scs_charge_sequencer (
        .sys_clk(sys_clk), .rst(rst), .battery_state_code(code), .state_valid(valid),
        .liion_mode(liion), .voutmax(VSET), .liion_vlimit(vlim),
        .liion_cur_limit(10'h3ff), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .scl_out(scl_out), .converter_hold_bit(hold),
        .trickle_mode(trickle), .hysteresis_flag(hyst), .startup_assist(assist),
        .charge_done(done), .panel_valid(panel), .wdt_expired(wdt), .loop_tick(tick),
        .meas_iin(m_iin), .meas_vin(m_vin), .meas_iout(m_iout), .meas_vout(m_vout));
    scs_conv_model u_scs_conv_model (.sys_clk(sys_clk), .rst(rst), .scl_out(scl_out),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .converter_hold_bit(hold),
        .zero_data(zero_data), .sda_in(sda_in), .edge_cnt(edge_cnt), .frame_bits(frame_bits));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic wait_tick();
        int k;
        for (k = 0; k < 4000 && tick !== 1'b1; k++)
            @(negedge sys_clk);
        `CHK(tick, 1'b1)
        @(negedge sys_clk);
    endtask : wait_tick
    // Second pass is the first that surely evaluated the new code.
    task automatic run(input logic [2:0] c, output int edges);
        int snap;
        code = c;
        wait_tick();
        snap = edge_cnt;
        wait_tick();
        edges = edge_cnt - snap;
        repeat (2) @(negedge sys_clk);
    endtask : run
    task automatic t_reset();
        `CHK({hold, hyst, scl_out, sda_oe_n, m_vout}, {4'hb, 16'h0000})
    endtask : t_reset
    task automatic t_fetch();
        run(3'h0, e0);
        `CHK({hold, hyst}, 2'h2)
        `CHK(m_vout, 16'h03ff)
        `CHK({m_iin, m_vin, m_iout}, {3{16'h03ff}})
        `CHK(e0 > 0, 1'b1)
        run(3'h1, e);
        `CHK(e >= e0 + SEND_BITS, 1'b1)
        `CHK(frame_bits, EXP_FRAME)
    endtask : t_fetch
    task automatic t_shut();
        run(3'h3, e);
        `CHK(hold, 1'b1)
        run(3'h4, e);
        `CHK(hold, 1'b1)
    endtask : t_shut
    task automatic t_hyst();
        run(3'h5, e);
        `CHK({hold, hyst}, 2'h3)
        run(3'h0, e);
        `CHK({hold, hyst}, 2'h3)
        run(3'h6, e);
        `CHK({hold, hyst}, 2'h0)
        `CHK(e >= e0 + SEND_BITS, 1'b1)
        `CHK(frame_bits, EXP_FRAME)
        run(3'h6, e);
        `CHK(e < e0 + SEND_BITS, 1'b1)
    endtask : t_hyst
    task automatic t_modes();
        run(3'h2, e);
        `CHK(trickle, 1'b1)
        zero_data = 1'b1;
        run(3'h0, e);
        `CHK({assist, panel}, 2'h2)
        zero_data = 1'b0;
        liion = 1'b1;
        run(3'h0, e);
        `CHK(done, 1'b0)
        vlim = 10'h100;
        run(3'h2, e);
        `CHK({done, trickle, hold}, 3'h5)
    endtask : t_modes
    task automatic t_wdt();
        valid = 1'b0;
        repeat (WDT + 100) @(negedge sys_clk);
        `CHK(wdt, 1'b1)
        valid = 1'b1;
        wait_tick();
        @(negedge sys_clk);
        `CHK(wdt, 1'b0)
    endtask : t_wdt
    initial
    begin
        repeat (20) @(negedge sys_clk);
        t_reset();
        rst = 1'b0;
        t_fetch();
        t_shut();
        t_hyst();
        t_modes();
        t_wdt();
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_reset();
        tally_and_finish();
    end
endmodule : scs_charge_sequencer_tb
